// >>> spidr_consts.svh
// constants of the serial port interrupt and dma register block
`ifndef SPIDR_CONSTS_SVH
`define SPIDR_CONSTS_SVH
// register byte offsets
`define SPIDR_OFF_TXTHR  8'h18
`define SPIDR_OFF_RXTHR  8'h1c
`define SPIDR_OFF_MASK   8'h2c
`define SPIDR_OFF_MSTAT  8'h30
`define SPIDR_OFF_RAW    8'h34
`define SPIDR_OFF_CLRTXO 8'h38
`define SPIDR_OFF_CLRRXO 8'h3c
`define SPIDR_OFF_CLRRXU 8'h40
`define SPIDR_OFF_CLRMST 8'h44
`define SPIDR_OFF_CLRALL 8'h48
`define SPIDR_OFF_DMACTL 8'h4c
`define SPIDR_OFF_TXDL   8'h50
`define SPIDR_OFF_RXDL   8'h54
`define SPIDR_OFF_IDENT  8'h58
`define SPIDR_OFF_VERS   8'h5c
`define SPIDR_OFF_DRLO   8'h60
`define SPIDR_OFF_DRHI   8'h9c
`define SPIDR_OFF_SPAREA 8'hf4
`define SPIDR_OFF_SPAREB 8'hf8
// interrupt bit positions
`define SPIDR_B_TXE 0
`define SPIDR_B_TXO 1
`define SPIDR_B_RXU 2
`define SPIDR_B_RXO 3
`define SPIDR_B_RXF 4
`define SPIDR_B_MST 5
// dma control bit positions
`define SPIDR_B_RDMA 0
`define SPIDR_B_TDMA 1
// reset values and fifo depth
`define SPIDR_MASK_RST 6'h3f
`define SPIDR_LVL_RST  3'h0
`define SPIDR_DMA_RST  2'h0
`define SPIDR_DEPTH    4'h8
`endif

// >>> spidr_engine_model.sv
// far-side shift engine model: takes transmit words, offers receive words
`default_nettype none
module spidr_engine_model (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // transmit side
  input  wire logic                   txValid,
  output logic                        txReady,
  input  wire spidr_pkg::spidr_word_t txData,
  // receive side
  output logic                        rxValid,
  output spidr_pkg::spidr_word_t      rxData,
  input  wire logic                   rxReady,
  // contention event
  output logic                        contentionPulse
);
  timeunit 1ns;
  timeprecision 1ps;
  import spidr_pkg::*;
  spidr_word_t txSeen[$];
  logic        stallTx;
  ////////////////////////////////////////////////////////////
  // idle levels; the engine starts stalled
  initial begin
    txReady = 1'h0;
    rxValid = 1'h0;
    rxData = 16'hffff;
    contentionPulse = 1'h0;
    stallTx = 1'h1;
  end
  // take each offered word unless stalled
  always @(posedge ref_clk) begin
    if (txValid && txReady)
      txSeen.push_back(txData);
    txReady <= rstn && !stallTx;
  end
  ////////////////////////////////////////////////////////////
  // stall or release the transmit side
  task automatic setStall(input logic s);
    @(posedge ref_clk);
    stallTx <= s;
    @(posedge ref_clk);
  endtask
  // offer one word for one cycle; full fifo drops it
  task automatic sendRx(input spidr_word_t d);
    rxValid <= 1'h1;
    rxData <= d;
    @(posedge ref_clk);
    rxValid <= 1'h0;
    rxData <= ~d; // released line shows no stale word
    @(posedge ref_clk);
  endtask
  // one-cycle contention event
  task automatic pulse();
    contentionPulse <= 1'h1;
    @(posedge ref_clk);
    contentionPulse <= 1'h0;
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// >>> spidr_fifo.sv
// eight-entry sixteen-bit flip-flop fifo
`default_nettype none
`include "spidr_consts.svh"
module spidr_fifo (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // fill side
  input  wire logic              pushValid,
  input  wire spidr_pkg::spidr_word_t pushData,
  output logic                   pushReady,
  // drain side
  output logic                   popValid,
  input  wire logic              popReady,
  output spidr_pkg::spidr_word_t popData,
  output spidr_pkg::spidr_lvl_t  level
);
  import spidr_pkg::*;
  spidr_fifo_st_t st_r;
  spidr_fifo_st_t st_nxt;
  logic           doPush;
  logic           doPop;

  ////////////////////////////////////////////////////////////////
  // handshake and data come straight from the stored entries
  assign pushReady = (st_r.cnt != `SPIDR_DEPTH);
  assign popValid  = (st_r.cnt != 4'h0);
  assign popData   = st_r.mem[st_r.rPtr];
  assign level     = st_r.cnt;
  assign doPush    = pushValid && pushReady;
  assign doPop     = popReady && popValid;

  // next state: write at head pointer, read at tail pointer
  always_comb begin
    st_nxt = st_r;
    if (doPush) begin
      st_nxt.mem[st_r.wPtr] = pushData;
      st_nxt.wPtr = st_r.wPtr + 3'h1;
    end
    if (doPop) begin
      st_nxt.rPtr = st_r.rPtr + 3'h1;
    end
    st_nxt.cnt = st_r.cnt + {3'h0, doPush} - {3'h0, doPop};
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> spidr_irq.sv
// sticky interrupt flags, mask and masked status
`default_nettype none
`include "spidr_consts.svh"
module spidr_irq (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // register side
  spidr_irq_if.irq  bus
);
  import spidr_pkg::*;
  spidr_irq_st_t st_r;
  spidr_irq_st_t st_nxt;

  ////////////////////////////////////////////////////////////////
  // raw word: level sources plus sticky events
  assign bus.raw    = {st_r.sticky[3], bus.rxFull, st_r.sticky[2], st_r.sticky[1], st_r.sticky[0], bus.txEmpty};
  assign bus.masked = bus.raw & st_r.mask;
  assign bus.mask   = st_r.mask;

  // a set in the clearing cycle survives the clear
  always_comb begin
    st_nxt = st_r;
    st_nxt.sticky = (st_r.sticky & ~bus.clrEvt) | bus.setEvt;
    if (bus.maskWr) begin
      st_nxt.mask = bus.maskWdata;
    end
  end

  // state register, mask leaves reset unmasked
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r.sticky <= 4'h0;
      st_r.mask   <= `SPIDR_MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_SET_WINS: assert property (bus.setEvt[0] |=> bus.raw[`SPIDR_B_TXO])
    else $error("event lost against clear");
  AST_MASK_GATE: assert property (bus.masked == (bus.raw & bus.mask))
    else $error("masked status differs from raw and mask");
  AST_MASK_RESET: assert property ($rose(rstn) |-> bus.mask == 6'h3f)
    else $error("mask not all ones after reset");
endmodule
`default_nettype wire

// >>> spidr_irq_if.sv
// carrier between the register block and its interrupt unit
`default_nettype none
interface spidr_irq_if;
  import spidr_pkg::*;
  logic [3:0] setEvt;
  logic [3:0] clrEvt;
  logic       maskWr;
  spidr_irq_t maskWdata;
  logic       txEmpty;
  logic       rxFull;
  spidr_irq_t raw;
  spidr_irq_t masked;
  spidr_irq_t mask;
  modport regs(output setEvt, clrEvt, maskWr, maskWdata, txEmpty, rxFull, input raw, masked, mask);
  modport irq(input setEvt, clrEvt, maskWr, maskWdata, txEmpty, rxFull, output raw, masked, mask);
endinterface
`default_nettype wire

// >>> spidr_pkg.sv
// types of the serial port interrupt and dma register block
`default_nettype none
package spidr_pkg;
  typedef logic [15:0] spidr_word_t;
  typedef logic [3:0]  spidr_lvl_t;
  typedef logic [2:0]  spidr_thr_t;
  typedef logic [5:0]  spidr_irq_t;
  // fifo state
  typedef struct packed {
    logic [7:0][15:0] mem;
    logic [2:0]       wPtr;
    logic [2:0]       rPtr;
    spidr_lvl_t       cnt;
  } spidr_fifo_st_t;
  // interrupt state: sticky {mst, rxo, rxu, txo}
  typedef struct packed {
    logic [3:0] sticky;
    spidr_irq_t mask;
  } spidr_irq_st_t;
  // register block state
  typedef struct packed {
    spidr_thr_t  txThr;
    spidr_thr_t  rxThr;
    spidr_thr_t  txDl;
    spidr_thr_t  rxDl;
    logic [1:0]  dmaCtl;
    logic [31:0] rdata;
    logic        err;
  } spidr_top_st_t;
endpackage
`default_nettype wire

// >>> spidr_regs.sv
// register block of a serial port: interrupts, dma requests, fifo data port
// How it works
// - raw status at 0x34 shows six interrupt conditions regardless of mask.
// - masked status bit 0 shows the unmasked transmit-empty interrupt, reset 1.
// - reading 0x38 clears transmit overflow; only bit 0 is nonzero.
// - reading 0x3c clears receive overflow only.
// - reading 0x40 clears receive underflow only.
// - reading 0x44 clears multi-master contention only.
// - dma control bit 1 enables transmit dma requests, reset 0.
// - dma control bit 0 enables receive dma requests, reset 0.
// - words 0x60 to 0x9c are the data port: read pops, write pushes.
// - offset 0x5c returns a fixed component version word.
// - offsets 0xf4 and 0xf8 are spare, read zero, do nothing.
// - mask bits: 1 unmasked, 0 masked, all reset to 1.
// - transmit empty is active while transmit level is at or below threshold.
`default_nettype none
`include "spidr_consts.svh"
module spidr_regs #(
  parameter logic [31:0] IDENT_VALUE   = 32'h0000_5a01, // arbitrary value
  parameter logic [31:0] VERSION_VALUE = 32'h0000_0100  // arbitrary value
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt and dma requests
  output logic             irq,
  output logic             txDmaReq,
  output logic             rxDmaReq,
  // transmit words to the shift engine
  output logic             txValid,
  input  wire logic        txReady,
  output spidr_pkg::spidr_word_t txData,
  // receive words from the shift engine
  input  wire logic        rxValid,
  input  wire spidr_pkg::spidr_word_t rxData,
  output logic             rxReady,
  // contention event from the shift engine
  input  wire logic        contentionPulse
);
  import spidr_pkg::*;
  spidr_top_st_t st_r;
  spidr_top_st_t st_nxt;
  spidr_irq_if   ib ();
  spidr_lvl_t    txLevel;
  spidr_lvl_t    rxLevel;
  spidr_word_t   rxHead;
  logic          txPushReady;
  logic          rxPopValid;
  logic          setup;
  logic          acc;
  logic          rdAcc;
  logic          wrAcc;
  logic          isData;
  logic          known;
  logic          txPush;
  logic          rxPop;

  ////////////////////////////////////////////////////////////////
  // apb phases; every access completes without wait states
  assign pready  = 1'b1;
  assign setup   = psel && !penable;
  assign acc     = psel && penable;
  assign rdAcc   = acc && !pwrite;
  assign wrAcc   = acc && pwrite;
  // a misaligned data port address is refused, so it neither pushes nor pops
  assign isData  = (paddr >= `SPIDR_OFF_DRLO) && (paddr <= `SPIDR_OFF_DRHI) && (paddr[1:0] == 2'h0);
  assign prdata  = st_r.rdata;
  assign pslverr = acc && st_r.err;

  // data port strobes; a pop of an empty fifo is an underflow
  assign txPush = wrAcc && isData;
  assign rxPop  = rdAcc && isData;

  ////////////////////////////////////////////////////////////////
  // transmit fifo, filled by software, drained by the shift engine
  spidr_fifo u_txfifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pushValid (txPush),
    .pushData  (pwdata[15:0]),
    .pushReady (txPushReady),
    .popValid  (txValid),
    .popReady  (txReady),
    .popData   (txData),
    .level     (txLevel)
  );

  // receive fifo, filled by the shift engine, drained by software
  spidr_fifo u_rxfifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pushValid (rxValid),
    .pushData  (rxData),
    .pushReady (rxReady),
    .popValid  (rxPopValid),
    .popReady  (rxPop),
    .popData   (rxHead),
    .level     (rxLevel)
  );

  ////////////////////////////////////////////////////////////////
  // interrupt unit
  spidr_irq u_irq (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .bus     (ib.irq)
  );

  // level sources of the raw word
  assign ib.txEmpty = ({1'b0, st_r.txThr} >= txLevel);
  assign ib.rxFull  = (rxLevel > {1'b0, st_r.rxThr});

  // sticky events {mst, rxo, rxu, txo}
  assign ib.setEvt = {contentionPulse, rxValid && !rxReady, rxPop && !rxPopValid, txPush && !txPushReady};

  // read clears; the raw word itself ignores writes
  always_comb begin
    ib.clrEvt = 4'h0;
    if (rdAcc) begin
      unique case (paddr)
        `SPIDR_OFF_CLRTXO: ib.clrEvt = 4'b0001;
        `SPIDR_OFF_CLRRXU: ib.clrEvt = 4'b0010;
        `SPIDR_OFF_CLRRXO: ib.clrEvt = 4'b0100;
        `SPIDR_OFF_CLRMST: ib.clrEvt = 4'b1000;
        `SPIDR_OFF_CLRALL: ib.clrEvt = 4'b1111;
        default:           ib.clrEvt = 4'h0;
      endcase
    end
  end

  // mask register write
  assign ib.maskWr    = wrAcc && paddr == `SPIDR_OFF_MASK;
  assign ib.maskWdata = pwdata[5:0];

  // interrupt output
  assign irq = |ib.masked;

  // dma requests
  assign txDmaReq = st_r.dmaCtl[`SPIDR_B_TDMA] && ({1'b0, st_r.txDl} >= txLevel);
  assign rxDmaReq = st_r.dmaCtl[`SPIDR_B_RDMA] && (rxLevel > {1'b0, st_r.rxDl});

  ////////////////////////////////////////////////////////////////
  // address decode: is the offset mapped
  always_comb begin
    known = 1'b1;
    unique case (paddr)
      `SPIDR_OFF_TXTHR, `SPIDR_OFF_RXTHR, `SPIDR_OFF_MASK, `SPIDR_OFF_MSTAT,
      `SPIDR_OFF_RAW, `SPIDR_OFF_CLRTXO, `SPIDR_OFF_CLRRXO, `SPIDR_OFF_CLRRXU,
      `SPIDR_OFF_CLRMST, `SPIDR_OFF_CLRALL, `SPIDR_OFF_DMACTL, `SPIDR_OFF_TXDL,
      `SPIDR_OFF_RXDL, `SPIDR_OFF_IDENT, `SPIDR_OFF_VERS, `SPIDR_OFF_SPAREA,
      `SPIDR_OFF_SPAREB: known = 1'b1;
      default:           known = isData;
    endcase
  end

  // read data is captured in the setup cycle, writes land in the access cycle
  always_comb begin
    st_nxt = st_r;
    if (setup) begin
      st_nxt.err   = !known || paddr[1:0] != 2'h0;
      st_nxt.rdata = 32'h0;
      if (!pwrite) begin
        unique case (paddr)
          `SPIDR_OFF_TXTHR:  st_nxt.rdata = {29'h0, st_r.txThr};
          `SPIDR_OFF_RXTHR:  st_nxt.rdata = {29'h0, st_r.rxThr};
          `SPIDR_OFF_MASK:   st_nxt.rdata = {26'h0, ib.mask};
          `SPIDR_OFF_MSTAT:  st_nxt.rdata = {26'h0, ib.masked};
          `SPIDR_OFF_RAW:    st_nxt.rdata = {26'h0, ib.raw};
          `SPIDR_OFF_CLRTXO: st_nxt.rdata = {31'h0, ib.raw[`SPIDR_B_TXO]};
          `SPIDR_OFF_CLRRXO: st_nxt.rdata = {31'h0, ib.raw[`SPIDR_B_RXO]};
          `SPIDR_OFF_CLRRXU: st_nxt.rdata = {31'h0, ib.raw[`SPIDR_B_RXU]};
          `SPIDR_OFF_CLRMST: st_nxt.rdata = {31'h0, ib.raw[`SPIDR_B_MST]};
          `SPIDR_OFF_CLRALL: st_nxt.rdata = {31'h0, |{ib.raw[`SPIDR_B_MST], ib.raw[3:1]}};
          `SPIDR_OFF_DMACTL: st_nxt.rdata = {30'h0, st_r.dmaCtl};
          `SPIDR_OFF_TXDL:   st_nxt.rdata = {29'h0, st_r.txDl};
          `SPIDR_OFF_RXDL:   st_nxt.rdata = {29'h0, st_r.rxDl};
          `SPIDR_OFF_IDENT:  st_nxt.rdata = IDENT_VALUE;
          `SPIDR_OFF_VERS:   st_nxt.rdata = VERSION_VALUE;
          default:           st_nxt.rdata = (isData && rxPopValid) ? {16'h0, rxHead} : 32'h0;
        endcase
      end
    end
    if (wrAcc) begin
      unique case (paddr)
        `SPIDR_OFF_TXTHR:  st_nxt.txThr = pwdata[2:0];
        `SPIDR_OFF_RXTHR:  st_nxt.rxThr = pwdata[2:0];
        `SPIDR_OFF_DMACTL: st_nxt.dmaCtl = pwdata[1:0];
        `SPIDR_OFF_TXDL:   st_nxt.txDl = pwdata[2:0];
        `SPIDR_OFF_RXDL:   st_nxt.rxDl = pwdata[2:0];
        default:           st_nxt.txThr = st_r.txThr;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r.txThr  <= `SPIDR_LVL_RST;
      st_r.rxThr  <= `SPIDR_LVL_RST;
      st_r.txDl   <= `SPIDR_LVL_RST;
      st_r.rxDl   <= `SPIDR_LVL_RST;
      st_r.dmaCtl <= `SPIDR_DMA_RST;
      st_r.rdata  <= 32'h0;
      st_r.err    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_TXO_RAISE: assert property (txPush && !txPushReady |=> ib.raw[1])
    else $error("transmit overflow not raised");
  AST_TXE_MASKED: assert property (ib.masked[0] == (ib.txEmpty && ib.mask[0]))
    else $error("masked transmit empty wrong");
  AST_CLR_TXO: assert property (rdAcc && paddr == 8'h38 && !ib.setEvt[0] |=> !ib.raw[1])
    else $error("transmit overflow not cleared");
  AST_CLR_RXO: assert property (rdAcc && paddr == 8'h3c && !ib.setEvt[2]
                                |=> !ib.raw[3] && ib.raw[1] == $past(ib.raw[1]))
    else $error("receive overflow clear wrong");
  AST_CLR_RXU: assert property (rdAcc && paddr == 8'h40 && !ib.setEvt[1] |=> !ib.raw[2])
    else $error("receive underflow not cleared");
  AST_CLR_MST: assert property (rdAcc && paddr == 8'h44 && !contentionPulse |=> !ib.raw[5])
    else $error("contention not cleared");
  AST_CLR_ALL: assert property (rdAcc && paddr == 8'h48 && ib.setEvt == 4'h0
                                |=> ib.raw[5] == 1'b0 && ib.raw[3:1] == 3'h0)
    else $error("combined clear incomplete");
  AST_TX_DMA: assert property (txDmaReq |-> st_r.dmaCtl[1] && txLevel <= {1'b0, st_r.txDl})
    else $error("transmit dma request without cause");
  AST_RX_DMA: assert property (rxDmaReq |-> st_r.dmaCtl[0] && rxLevel > {1'b0, st_r.rxDl})
    else $error("receive dma request without cause");
  AST_DR_POP: assert property (rxPop && rxPopValid && !rxValid |=> rxLevel == $past(rxLevel) - 4'h1)
    else $error("data port read did not pop");
  AST_VERSION: assert property (setup && !pwrite && paddr == 8'h5c |=> prdata == VERSION_VALUE)
    else $error("version word wrong");
  AST_SPARE: assert property (setup && !pwrite && (paddr == 8'hf4 || paddr == 8'hf8) |=> prdata == 32'h0)
    else $error("spare word not zero");
  AST_TXE_LEVEL: assert property (ib.raw[0] == (txLevel <= {1'b0, st_r.txThr}))
    else $error("transmit empty level wrong");
  AST_IRQ_OR: assert property (irq == (ib.masked != 6'h0))
    else $error("interrupt output not or of masked");
  // the raw word is read-only: a write leaves every sticky bit as it was
  AST_RAW_RO: assert property (wrAcc && paddr == 8'h34 && ib.setEvt == 4'h0
                               |=> {ib.raw[5], ib.raw[3:1]} == $past({ib.raw[5], ib.raw[3:1]}))
    else $error("write changed raw status");
  // clear words carry one meaningful bit
  AST_CLR_TXO_DATA: assert property (setup && !pwrite && paddr == 8'h38 |=> prdata[31:1] == 31'h0)
    else $error("clear word upper bits not zero");
  // combined clear reports what was pending before it
  AST_ALL_DATA: assert property (setup && !pwrite && paddr == 8'h48
                                 |=> prdata == {31'h0, $past(ib.raw[5] | ib.raw[3] | ib.raw[2] | ib.raw[1])})
    else $error("combined clear word wrong");
  // dma enables leave reset off
  AST_DMA_RESET: assert property ($rose(rstn) |-> st_r.dmaCtl == 2'h0)
    else $error("dma enables not off after reset");
  // a data port write into a free slot adds one entry
  AST_DR_PUSH: assert property (txPush && txPushReady && !(txValid && txReady)
                                |=> txLevel == $past(txLevel) + 4'h1)
    else $error("data port write did not push");
  // data port reads show only sixteen bits
  AST_DR_UPPER: assert property (setup && !pwrite && isData |=> prdata[31:16] == 16'h0)
    else $error("data port upper bits not zero");
  // an unmapped or misaligned address raises the error flag
  AST_ERR_FLAG: assert property (setup && !known |=> st_r.err)
    else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// >>> spidr_regs_bench.sv
// self-checking bench of the serial port interrupt and dma register block
`default_nettype none
module spidr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import spidr_pkg::*;
  localparam logic [31:0] IDV = 32'h0000_1234; // arbitrary value
  localparam logic [31:0] VRV = 32'h0000_0207; // arbitrary value
  logic        ref_clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        txDmaReq;
  logic        rxDmaReq;
  logic        txValid;
  logic        txReady;
  spidr_word_t txData;
  logic        rxValid;
  spidr_word_t rxData;
  logic        rxReady;
  logic        contentionPulse;
  int          failCount = 0;
  int          checksDone = 0;
  int          cycles = 0;
  ////////////////////////////////////////////////////////////
  // block and far-side engine
  spidr_regs #(.IDENT_VALUE(IDV), .VERSION_VALUE(VRV)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .txDmaReq(txDmaReq),
    .rxDmaReq(rxDmaReq), .txValid(txValid), .txReady(txReady), .txData(txData),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
    .contentionPulse(contentionPulse));
  spidr_engine_model eng (
    .ref_clk(ref_clk), .rstn(rstn), .txValid(txValid), .txReady(txReady),
    .txData(txData), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
    .contentionPulse(contentionPulse));
  ////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checksDone++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // compare a settled output pin
  task automatic pin(ref logic g, input logic e);
    @(negedge ref_clk);
    chk({31'h0, g}, {31'h0, e});
    @(posedge ref_clk);
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    rd = prdata; // taken at the edge that sees pready high
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic        e;
    apb(1'h1, a, d, v, e);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] v;
    logic        e;
    apb(1'h0, a, 32'h0, v, e);
    chk(v, x);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic scnReset();
    rd(8'h2c, 32'h3f);
    rd(8'h4c, 32'h0);
    rd(8'h50, 32'h0);
    rd(8'h54, 32'h0);
    rd(8'h58, IDV);
    rd(8'h34, 32'h1);
    rd(8'h30, 32'h1);
    wr(8'hf4, 32'hffff_ffff);
    rd(8'hf4, 32'h0);
    rd(8'hf8, 32'h0);
    wr(8'h5c, 32'h0);
    rd(8'h5c, VRV);
    pin(irq, 1'h1);
  endtask
  task automatic scnTx();
    wr(8'h18, 32'h3);
    wr(8'h50, 32'h3);
    pin(txDmaReq, 1'h0);
    wr(8'h4c, 32'h2);
    pin(txDmaReq, 1'h1);
    pin(rxDmaReq, 1'h0);
    for (int i = 0; i < 9; i++) begin
      wr(8'h9c - 8'(4 * i), {16'h0, 16'ha500 + 16'(i)});
      if (i == 2) rd(8'h34, 32'h1);
      if (i == 3) rd(8'h34, 32'h0);
      if (i == 3) pin(txDmaReq, 1'h0);
    end
    rd(8'h34, 32'h2);
    rd(8'h30, 32'h2);
  endtask
  task automatic scnMask();
    wr(8'h2c, 32'h0);
    pin(irq, 1'h0);
    rd(8'h30, 32'h0);
    rd(8'h34, 32'h2);
    wr(8'h2c, 32'h2);
    pin(irq, 1'h1);
    wr(8'h2c, 32'h3f);
    wr(8'h34, 32'h3f);
    rd(8'h38, 32'h1);
    rd(8'h38, 32'h0);
    rd(8'h34, 32'h0);
    pin(irq, 1'h0);
  endtask
  task automatic scnDrain();
    eng.setStall(1'h0);
    while (txValid !== 1'h0) @(negedge ref_clk);
    @(posedge ref_clk);
    chk(32'(eng.txSeen.size()), 32'h8);
    for (int i = 0; i < 8; i++) chk({16'h0, eng.txSeen[i]}, 32'ha500 + 32'(i));
    eng.setStall(1'h1);
    rd(8'h34, 32'h1);
  endtask
  task automatic scnRx();
    wr(8'h1c, 32'h0);
    wr(8'h54, 32'h1);
    wr(8'h4c, 32'h1);
    for (int i = 0; i < 9; i++) begin
      eng.sendRx(16'h5a00 + 16'(i));
      if (i == 0) pin(rxDmaReq, 1'h0);
      if (i == 1) pin(rxDmaReq, 1'h1);
    end
    pin(txDmaReq, 1'h0);
    rd(8'h34, 32'h19);
    rd(8'h3c, 32'h1);
    rd(8'h34, 32'h11);
    for (int i = 0; i < 9; i++) rd(8'h60 + 8'(4 * i), i < 8 ? 32'h5a00 + 32'(i) : 32'h0);
    rd(8'h34, 32'h5);
    rd(8'h40, 32'h1);
    rd(8'h34, 32'h1);
  endtask
  task automatic scnAll();
    eng.pulse();
    rd(8'h34, 32'h21);
    rd(8'h44, 32'h1);
    rd(8'h34, 32'h1);
    eng.pulse();
    rd(8'h60, 32'h0);
    for (int i = 0; i < 9; i++) wr(8'h60, 32'h0);
    rd(8'h34, 32'h26);
    rd(8'h48, 32'h1);
    rd(8'h34, 32'h0);
    rd(8'h48, 32'h0);
  endtask
  task automatic scnErr();
    logic [31:0] v;
    logic        e;
    apb(1'h0, 8'h00, 32'h0, v, e);
    chk({31'h0, e}, 32'h1);
    chk(v, 32'h0);
    apb(1'h1, 8'h62, 32'h0, v, e);
    chk({31'h0, e}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////
  // clock
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failCount++;
      wrapUp();
    end
  end
  // main sequence
  initial begin
    rstn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'h1;
    @(posedge ref_clk);
    scnReset();
    scnTx();
    scnMask();
    scnDrain();
    scnRx();
    scnAll();
    scnErr();
    wrapUp();
  end
endmodule
`default_nettype wire
